// [rtl/shift_bit_unit_regs.vh]
/*
 * Register offsets, field positions, reset values, operation codes and
 * cycle counts for the shift, bit and stack-pop execution unit.
 * Assumes inclusion by bare name from the design files of that unit.
 */
`ifndef SHIFT_BIT_UNIT_REGS_VH
`define SHIFT_BIT_UNIT_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CMD          8'h00
`define OFS_DEST         8'h04
`define OFS_FLAGS        8'h08
`define OFS_IO_ADDR      8'h0C
`define OFS_STACK_PTR    8'h10
`define OFS_STATUS       8'h14

// ----------------------------------------------------------------------
// command fields
// ----------------------------------------------------------------------
`define CMD_OP_MSB       3
`define CMD_OP_LSB       0
`define CMD_BIT_MSB      6
`define CMD_BIT_LSB      4

// ----------------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------------
`define OP_IO_BIT_SET    4'h0
`define OP_IO_BIT_CLEAR  4'h1
`define OP_LSL           4'h2
`define OP_LSR           4'h3
`define OP_ROL           4'h4
`define OP_ROR           4'h5
`define OP_ASR           4'h6
`define OP_SWAP          4'h7
`define OP_POP           4'h8

// ----------------------------------------------------------------------
// status flag bit positions
// ----------------------------------------------------------------------
`define FLAG_C           0
`define FLAG_Z           1
`define FLAG_N           2
`define FLAG_V           3
`define FLAG_S           4
`define FLAG_H           5
`define FLAG_T           6
`define FLAG_I           7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_DEST         8'h00
`define RST_FLAGS        8'h00
`define RST_IO_ADDR      6'h00
`define RST_STACK_PTR    16'h0000

// ----------------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------------
`define CYC_IO_BIT       2
`define CYC_SHIFT        1
`define CYC_POP          2

`endif

// [rtl/ahb_lite_front.v]
/*
 * AHB-Lite slave front end: turns bus transfers into one-cycle write and
 * read strobes for the register file.
 * Assumes a single slave whose hreadyout is the bus hready, word transfers.
 */
`timescale 1ns/1ns
`default_nettype none

module ahb_lite_front (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        ce,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output wire        hreadyout,
	output wire        hresp,
	output wire        wr_en,
	output wire        rd_en,
	output wire [7:0]  reg_addr,
	output wire [31:0] wr_data
);

	reg       wr_pend;
	reg       rd_pend;
	reg [7:0] addr_q;
	wire      accept;

	// ------------------------------------------------------------------
	// address phase capture
	// ------------------------------------------------------------------
	assign accept = hsel & hready & htrans[1];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			addr_q  <= 8'h00;
		end else if (ce) begin
			wr_pend <= accept & hwrite;
			rd_pend <= accept & ~hwrite;
			if (accept)
				addr_q <= haddr[7:0];
		end
	end

	// ------------------------------------------------------------------
	// data phase strobes
	// ------------------------------------------------------------------
	// reads take one wait state so read data comes from a flip-flop
	assign hreadyout = ~rd_pend;
	assign hresp     = 1'b0;
	assign wr_en     = wr_pend & ce;
	assign rd_en     = rd_pend & ce;
	assign reg_addr  = addr_q;
	assign wr_data   = hwdata;

endmodule // ahb_lite_front

`default_nettype wire

// [rtl/shift_flag_unit.v]
/*
 * Combinational shift, rotate and nibble-swap datapath with flag update.
 * Assumes op codes from the unit header; unused ops pass data through.
 */
`timescale 1ns/1ns
`default_nettype none

`include "shift_bit_unit_regs.vh"

module shift_flag_unit (
	input  wire [3:0] op,
	input  wire [7:0] din,
	input  wire [7:0] flags_in,
	output reg  [7:0] dout,
	output reg  [7:0] flags_out
);

	reg carry_out;

	// ------------------------------------------------------------------
	// zero, carry, negative, overflow from result and carry
	// ------------------------------------------------------------------
	function [7:0] zcnv;
		input [7:0] f;
		input [7:0] r;
		input       c;
		begin
			zcnv            = f;
			zcnv[`FLAG_Z]   = (r == 8'h00);
			zcnv[`FLAG_C]   = c;
			zcnv[`FLAG_N]   = r[7];
			zcnv[`FLAG_V]   = r[7] ^ c;
		end
	endfunction

	// ------------------------------------------------------------------
	// datapath
	// ------------------------------------------------------------------
	always @* begin
		dout      = din;
		carry_out = flags_in[`FLAG_C];
		flags_out = flags_in; // RULE_10
		case (op)
			`OP_LSL: begin
				dout      = {din[6:0], 1'b0}; // RULE_03
				carry_out = din[7];
				flags_out = zcnv(flags_in, dout, carry_out); // RULE_03
			end
			`OP_LSR: begin
				dout      = {1'b0, din[7:1]}; // RULE_04
				carry_out = din[0];
				flags_out = zcnv(flags_in, dout, carry_out); // RULE_04
			end
			`OP_ROL: begin
				dout      = {din[6:0], flags_in[`FLAG_C]}; // RULE_05
				carry_out = din[7]; // RULE_05
				flags_out = zcnv(flags_in, dout, carry_out);
			end
			`OP_ROR: begin
				dout      = {flags_in[`FLAG_C], din[7:1]}; // RULE_06
				carry_out = din[0]; // RULE_06
				flags_out = zcnv(flags_in, dout, carry_out);
			end
			`OP_ASR: begin
				dout      = {din[7], din[7:1]}; // RULE_07
				carry_out = din[0];
				flags_out = zcnv(flags_in, dout, carry_out); // RULE_07
			end
			`OP_SWAP: begin
				dout      = {din[3:0], din[7:4]}; // RULE_08
			end
			default: begin
				dout      = din;
			end
		endcase
	end

endmodule // shift_flag_unit

`default_nettype wire

// [rtl/shift_bit_stack_ops_unit.v]
/*
 * Execution unit for I/O bit set/clear, shifts, rotates through carry,
 * nibble swap and stack pop, driven over an AHB-Lite register bus.
 * Assumes io_rdata and stack_rdata answer in the same cycle as their
 * read strobe, and that the I/O and stack memories accept a write or
 * read on every cycle with the strobe high.
 */
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

`include "shift_bit_unit_regs.vh"

// Summary of operation
// RULE_01: I/O bit set forces one addressed bit high, flags untouched, two cycles.
// RULE_02: I/O bit clear forces one addressed bit low, flags untouched, two cycles.
// RULE_03: logical left shift, zero into bit 0, updates Z C N V, one cycle.
// RULE_04: logical right shift, zero into bit 7, updates Z C N V, one cycle.
// RULE_05: rotate left: carry into bit 0, bit 7 into carry, Z C N V, one cycle.
// RULE_06: rotate right: carry into bit 7, bit 0 into carry, Z C N V, one cycle.
// RULE_07: arithmetic right shift keeps bit 7, updates Z C N V, one cycle.
// RULE_08: nibble swap exchanges halves in one cycle, no flag changes.
// RULE_09: stack pop loads destination, adjusts stack pointer, no flags, two cycles.
// RULE_10: flags an operation does not name keep their previous values.
module shift_bit_stack_ops_unit (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        ce,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	output reg  [5:0]  io_addr,
	output reg  [7:0]  io_wdata,
	output wire        io_re,
	output wire        io_we,
	input  wire [7:0]  io_rdata,
	output reg  [15:0] stack_addr,
	output wire        stack_re,
	input  wire [7:0]  stack_rdata,
	output wire        busy
);

	// ------------------------------------------------------------------
	// states
	// ------------------------------------------------------------------
	localparam [2:0] ST_IDLE  = 3'd0;
	localparam [2:0] ST_SHIFT = 3'd1;
	localparam [2:0] ST_IO_RD = 3'd2;
	localparam [2:0] ST_IO_WR = 3'd3;
	localparam [2:0] ST_POP_1 = 3'd4;
	localparam [2:0] ST_POP_2 = 3'd5;

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg  [3:0]  op;
	reg  [2:0]  bit_sel;
	reg  [7:0]  dest;
	reg  [7:0]  status_flags_reg;
	reg  [15:0] stack_ptr;
	reg  [7:0]  done_count;
	reg  [31:0] read_word;
	wire        wr_en;
	wire        rd_en;
	wire [7:0]  reg_addr;
	wire [31:0] wr_data;
	wire [7:0]  shift_out;
	wire [7:0]  shift_flags;
	wire        cmd_wr;
	wire [3:0]  cmd_op;
	wire        cmd_ok;
	wire        op_done;
	wire        dest_wr;
	wire        flags_wr;
	wire        io_addr_wr;
	wire        sp_wr;
	wire [15:0] sp_next;
	wire [31:0] status_word;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function is_valid_op;
		input [3:0] code;
		begin
			is_valid_op = (code <= `OP_POP);
		end
	endfunction

	function [7:0] bit_mask;
		input [2:0] idx;
		begin
			bit_mask = 8'h01 << idx;
		end
	endfunction

	function addr_hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			addr_hit = (addr == ofs);
		end
	endfunction

	// ------------------------------------------------------------------
	// bus front end and datapath
	// ------------------------------------------------------------------
	ahb_lite_front u_front (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hwdata    (hwdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.wr_en     (wr_en),
		.rd_en     (rd_en),
		.reg_addr  (reg_addr),
		.wr_data   (wr_data)
	);

	shift_flag_unit u_shift (
		.op        (op),
		.din       (dest),
		.flags_in  (status_flags_reg),
		.dout      (shift_out),
		.flags_out (shift_flags)
	);

	// ------------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------------
	assign cmd_op  = wr_data[`CMD_OP_MSB:`CMD_OP_LSB];
	assign cmd_wr  = wr_en && addr_hit(reg_addr, `OFS_CMD);
	// commands while busy or with unknown codes are dropped
	assign cmd_ok  = cmd_wr && (state == ST_IDLE) && is_valid_op(cmd_op);
	assign busy    = (state != ST_IDLE);
	assign io_re   = ce && (state == ST_IO_RD);
	assign io_we   = ce && (state == ST_IO_WR);
	assign stack_re = ce && (state == ST_POP_1);
	assign op_done = (state == ST_SHIFT) || (state == ST_IO_WR) ||
	                 (state == ST_POP_2);
	assign dest_wr    = wr_en && addr_hit(reg_addr, `OFS_DEST);
	assign flags_wr   = wr_en && addr_hit(reg_addr, `OFS_FLAGS);
	// pointer and address writes are ignored while an operation runs
	assign io_addr_wr = wr_en && addr_hit(reg_addr, `OFS_IO_ADDR) && (state == ST_IDLE);
	assign sp_wr      = wr_en && addr_hit(reg_addr, `OFS_STACK_PTR) && (state == ST_IDLE);
	assign sp_next    = stack_ptr + 16'h0001; // RULE_09
	assign status_word = {16'h0000, done_count, 4'h0, 1'b0, state};

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (cmd_ok) begin
					case (cmd_op)
						`OP_IO_BIT_SET:   next_state = ST_IO_RD; // RULE_01
						`OP_IO_BIT_CLEAR: next_state = ST_IO_RD; // RULE_02
						`OP_POP:          next_state = ST_POP_1; // RULE_09
						default:          next_state = ST_SHIFT;
					endcase
				end
			end
			ST_SHIFT: next_state = ST_IDLE;
			ST_IO_RD: next_state = ST_IO_WR;
			ST_IO_WR: next_state = ST_IDLE;
			ST_POP_1: next_state = ST_POP_2;
			ST_POP_2: next_state = ST_IDLE;
			default:  next_state = ST_IDLE;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state   <= ST_IDLE;
			op      <= `OP_IO_BIT_SET;
			bit_sel <= 3'd0;
		end else if (ce) begin
			state <= next_state;
			if (cmd_ok) begin
				op      <= cmd_op;
				bit_sel <= wr_data[`CMD_BIT_MSB:`CMD_BIT_LSB];
			end
		end
	end

	// ------------------------------------------------------------------
	// destination register and flags
	// ------------------------------------------------------------------
	// hardware update wins over a software write in the same cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dest <= `RST_DEST;
		end else if (ce) begin
			if (state == ST_SHIFT)
				dest <= shift_out;
			else if (state == ST_POP_1)
				dest <= stack_rdata; // RULE_09
			else if (dest_wr)
				dest <= wr_data[7:0];
		end
	end

	// only shifts touch the flags; pops and bit ops leave them alone
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_flags_reg <= `RST_FLAGS;
		end else if (ce) begin
			if (state == ST_SHIFT)
				status_flags_reg <= shift_flags; // RULE_10
			else if (flags_wr)
				status_flags_reg <= wr_data[7:0];
		end
	end

	// ------------------------------------------------------------------
	// I/O bit read-modify-write
	// ------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			io_addr  <= `RST_IO_ADDR;
			io_wdata <= 8'h00;
		end else if (ce) begin
			if (io_addr_wr)
				io_addr <= wr_data[5:0];
			if (state == ST_IO_RD) begin
				if (op == `OP_IO_BIT_SET)
					io_wdata <= io_rdata | bit_mask(bit_sel); // RULE_01
				else
					io_wdata <= io_rdata & ~bit_mask(bit_sel); // RULE_02
			end
		end
	end

	// ------------------------------------------------------------------
	// stack pointer
	// ------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stack_ptr  <= `RST_STACK_PTR;
			stack_addr <= `RST_STACK_PTR;
		end else if (ce) begin
			if (cmd_ok && (cmd_op == `OP_POP)) begin
				stack_ptr  <= sp_next; // RULE_09
				stack_addr <= sp_next;
			end else if (sp_wr) begin
				stack_ptr  <= wr_data[15:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// completion counter
	// ------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			done_count <= 8'h00;
		else if (ce && op_done)
			done_count <= done_count + 8'h01;
	end

	// ------------------------------------------------------------------
	// read data
	// ------------------------------------------------------------------
	always @* begin
		case (reg_addr)
			`OFS_CMD:       read_word = {25'h0000000, bit_sel, op};
			`OFS_DEST:      read_word = {24'h000000, dest};
			`OFS_FLAGS:     read_word = {24'h000000, status_flags_reg};
			`OFS_IO_ADDR:   read_word = {26'h0000000, io_addr};
			`OFS_STACK_PTR: read_word = {16'h0000, stack_ptr};
			`OFS_STATUS:    read_word = status_word;
			default:        read_word = 32'h00000000;
		endcase
	end

	// registered so the data phase sees a settled word
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (rd_en)
			hrdata <= read_word;
	end

endmodule // shift_bit_stack_ops_unit

`default_nettype wire

// [tb/shift_ops_checker_sva.sv]
/*
 * Concurrent checks on the shift, bit and pop unit's ports.
 * Assumes ce is held high by the bench and one clock domain.
 */
`timescale 1ns/1ns
`default_nettype none

module shift_ops_checker (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       ce,
	input wire logic       hsel,
	input wire logic       hready,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hreadyout,
	input wire logic       io_re,
	input wire logic       io_we,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic       stack_re,
	input wire logic       busy
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_io_rd_wr;
		io_re && ce |=> io_we && !io_re;
	endproperty
	a_io_rd_wr: assert property (p_io_rd_wr) else $error("write-back missing");
	property p_io_done;
		io_we && ce |=> !io_we && !busy;
	endproperty
	a_io_done: assert property (p_io_done) else $error("bit op too long");
	property p_io_one_bit;
		io_we && $past(io_re) |-> $stable(io_addr) && $countones(io_wdata ^ $past(io_rdata)) <= 1;
	endproperty
	a_io_one_bit: assert property (p_io_one_bit) else $error("more than one bit");
	property p_io_cycle;
		$rose(busy) && io_re |=> io_we ##1 !busy;
	endproperty
	a_io_cycle: assert property (p_io_cycle) else $error("bit op not two cycles");
	property p_pop_len;
		stack_re && ce |=> busy && !stack_re ##1 !busy;
	endproperty
	a_pop_len: assert property (p_pop_len) else $error("pop not two cycles");
	property p_no_overlap;
		io_re |-> !io_we && !stack_re && busy;
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("strobes overlap");
	property p_busy_bound;
		$rose(busy) |-> ##[1:3] !busy;
	endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
	property p_quiet;
		!busy |-> !io_re && !io_we && !stack_re;
	endproperty
	a_quiet: assert property (p_quiet) else $error("strobe while idle");
	property p_read_wait;
		hsel && hready && htrans[1] && !hwrite && ce |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
endmodule // shift_ops_checker

bind shift_bit_stack_ops_unit shift_ops_checker shift_ops_checker_inst (
	.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .hready(hready),
	.htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .io_re(io_re),
	.io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
	.stack_re(stack_re), .busy(busy)
);

`default_nettype wire

// [tb/far_side_model.sv]
/*
 * I/O register space and stack memory behind the unit.
 * Assumes same-cycle read data; stack indexed by the low address byte.
 */
`timescale 1ns/1ns
`default_nettype none

module far_side_model (
	input wire logic        hclk,
	input wire logic [5:0]  io_addr,
	input wire logic [7:0]  io_wdata,
	input wire logic        io_re,
	input wire logic        io_we,
	output logic [7:0]      io_rdata,
	input wire logic [15:0] stack_addr,
	input wire logic        stack_re,
	output logic [7:0]      stack_rdata
);
	logic [7:0] io_mem [64];
	logic [7:0] stk [256];
	logic [7:0] noise;

	initial begin
		noise = 8'h00;
		for (int i = 0; i < 256; i++) begin
			stk[i] = 8'(i * 8'h5B) ^ 8'hC3;
			if (i < 64)
				io_mem[i] = 8'(i * 8'h3B) ^ 8'hA5;
		end
	end

	// undriven reads show a moving pattern
	always @(posedge hclk) begin
		noise <= noise + 8'h35;
		if (io_we)
			io_mem[io_addr] <= io_wdata;
	end
	assign io_rdata = io_re ? io_mem[io_addr] : noise;
	assign stack_rdata = stack_re ? stk[stack_addr[7:0]] : ~noise;
endmodule // far_side_model

`default_nettype wire

// [tb/testbench.sv]
/*
 * Self-checking bench: AHB-Lite master, random shifts, bit ops and pops.
 * Assumes the unit's header and the far side model.
 */
`timescale 1ns/1ns
`default_nettype none

`include "shift_bit_unit_regs.vh"

module testbench;
	logic hclk, hresetn, ce, hsel, hwrite;
	logic [31:0] haddr, hwdata, rd, seed;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire hready, hresp, io_re, io_we, stack_re, busy;
	wire [31:0] hrdata;
	wire [5:0] io_addr;
	wire [7:0] io_wdata, io_rdata, stack_rdata;
	wire [15:0] stack_addr;
	int bad_count, checks;
	logic [7:0] d, f, b4;
	logic [15:0] sp;
	logic [15:0] e;
	logic [7:0] probe [5] = '{`OFS_DEST, `OFS_FLAGS, `OFS_IO_ADDR, `OFS_STACK_PTR, 8'h18};
	logic [7:0] corner [3] = '{8'h00, 8'h80, 8'hFF};

	shift_bit_stack_ops_unit shift_bit_stack_ops_unit_inst (.hclk(hclk), .hresetn(hresetn),
		.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hready),
		.hresp(hresp), .hrdata(hrdata), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_re(io_re), .io_we(io_we), .io_rdata(io_rdata), .stack_addr(stack_addr),
		.stack_re(stack_re), .stack_rdata(stack_rdata), .busy(busy));
	far_side_model far_side_model_inst (.hclk(hclk), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_re(io_re), .io_we(io_we), .io_rdata(io_rdata),
		.stack_addr(stack_addr), .stack_re(stack_re), .stack_rdata(stack_rdata));

	always #5 hclk = ~hclk;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// returns {flags, result}
	function automatic logic [15:0] calc(input logic [3:0] op, input logic [7:0] x,
		input logic [7:0] fl);
		logic [7:0] r;
		logic c;
		c = x[0];
		case (op)
			`OP_LSL: {c, r} = {x, 1'b0};
			`OP_LSR: r = {1'b0, x[7:1]};
			`OP_ROL: {c, r} = {x, fl[`FLAG_C]};
			`OP_ROR: r = {fl[`FLAG_C], x[7:1]};
			`OP_ASR: r = {x[7], x[7:1]};
			default: return {fl, x[3:0], x[7:4]};
		endcase
		fl[`FLAG_C] = c;
		fl[`FLAG_Z] = (r == 8'h00);
		fl[`FLAG_N] = r[7];
		fl[`FLAG_V] = r[7] ^ c;
		return {fl, r};
	endfunction

	task final_report;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		logic r;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		// hready and hrdata are taken settled, half a cycle before the edge
		do begin
			@(negedge hclk);
			r = hready;
			@(posedge hclk);
			n++;
		end while (r !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(negedge hclk);
			r = hready;
			rd = hrdata;
			@(posedge hclk);
			n++;
		end while (r !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			final_report;
		end
	endtask

	task run(input logic [7:0] cmd);
		int n;
		n = 0;
		bus(1'b1, `OFS_FLAGS, {24'h000000, f});
		bus(1'b1, `OFS_CMD, {24'h000000, cmd});
		do begin bus(1'b0, `OFS_STATUS, 32'h0); n++; end while (rd[2:0] !== 3'h0 && n < 20);
		if (n >= 20) begin
			bad_count++;
			final_report;
		end
		bus(1'b0, `OFS_FLAGS, 32'h0);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		seed = 32'hE360;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b1, 8'h18, 32'hFFFFFFFF);
		foreach (probe[i]) begin
			bus(1'b0, probe[i], 32'h0);
			chk(rd, 32'h0);
			chk({31'h0, hresp}, 32'h0);
		end
		for (int k = 0; k < 42; k++) begin
			seed = xs(seed);
			d = (k < 18) ? corner[k / 6] : seed[7:0];
			f = seed[15:8];
			bus(1'b1, `OFS_DEST, {24'h000000, d});
			run(8'(2 + k % 6));
			e = calc(4'(2 + k % 6), d, f);
			chk(rd[7:0], e[15:8]);
			bus(1'b0, `OFS_DEST, 32'h0);
			chk(rd[7:0], e[7:0]);
		end
		for (int k = 0; k < 16; k++) begin
			seed = xs(seed);
			f = seed[15:8];
			b4 = far_side_model_inst.io_mem[seed[5:0]];
			bus(1'b1, `OFS_IO_ADDR, {26'h0, seed[5:0]});
			run({1'b0, seed[18:16], 4'(k % 2)});
			chk(rd[7:0], f);
			b4[seed[18:16]] = (k % 2 == 0);
			chk(far_side_model_inst.io_mem[seed[5:0]], b4);
		end
		for (int k = 0; k < 6; k++) begin
			seed = xs(seed);
			f = seed[15:8];
			sp = (k == 0) ? 16'hFFFF : seed[31:16];
			bus(1'b1, `OFS_STACK_PTR, {16'h0000, sp});
			run({4'h0, `OP_POP});
			chk(rd[7:0], f);
			bus(1'b0, `OFS_DEST, 32'h0);
			chk(rd[7:0], far_side_model_inst.stk[8'(sp + 16'h1)]);
			bus(1'b0, `OFS_STACK_PTR, 32'h0);
			chk(rd, {16'h0000, 16'(sp + 16'h1)});
		end
		// unknown op code is dropped: idle, 64 ops counted, last command kept
		bus(1'b1, `OFS_CMD, 32'h0000000F);
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk(rd, 32'h00004000);
		bus(1'b0, `OFS_CMD, 32'h0);
		chk(rd, 32'h00000008);
		final_report;
	end
endmodule // testbench

`default_nettype wire
